// ### throttle_position_decoder_tb.sv
module throttle_position_decoder_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tpd_pkg::*;
  logic       clk_i;
  logic       rstn_i = 1'b0;
  logic [3:0] notch  = 4'h0;
  tpd_sol_t   sol;
  logic [6:0] iso_n;
  logic [6:0] shr;
  logic [9:0] lvl;
  tpd_pos_t   pos;
  int         num_errors = 0;
  int         tests_run  = 0;
  localparam logic [9:0] LVL [11] = '{TPD_LVL_IDLE, TPD_LVL_IDLE, TPD_LVL_POS1, TPD_LVL_POS1, TPD_LVL_POS2,
    TPD_LVL_POS3, TPD_LVL_POS4, TPD_LVL_POS5, TPD_LVL_POS6, TPD_LVL_POS7, TPD_LVL_POS8};
  tpd_ctrl_model tpd_ctrl_model_inst (.notch_i(notch), .sol_o(sol));
  tpd_throttle_position_decoder tpd_throttle_position_decoder_inst (.clk_i(clk_i), .rstn_i(rstn_i),
    .sol_i(sol), .isolator_pos_n_o(iso_n), .shorted_res_o(shr), .rate_control_unit_level_o(lvl), .position_o(pos));
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////
  task automatic chk_vec(input string what, input logic [9:0] e, input logic [9:0] g);
    tests_run++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_pos(input tpd_pos_t e, input tpd_pos_t g);
    chk_vec("position", {6'h0, e}, {6'h0, g});
  endtask
  task automatic chk_notch(input int n);
    chk_vec("isolator", {3'h0, n < 4 ? 7'h7f : ~(7'h01 << (n - 4))}, {3'h0, iso_n});
    chk_vec("shorted", {3'h0, n < 4 ? 7'h00 : 7'h7f >> (10 - n)}, {3'h0, shr});
    chk_vec("level", LVL[n], lvl);
    chk_pos(tpd_pos_t'(n < 3 ? n : n - 1), pos);
  endtask
  task automatic do_reset();
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic t_sweep();
    for (int n = 0; n < 11; n++)
    begin
      @(posedge clk_i);
      notch <= 4'(n);
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      chk_notch(n);
    end
  endtask
  task automatic t_b2b();
    int s [3] = '{4, 7, 5};
    foreach (s[i])
    begin
      @(posedge clk_i);
      notch <= 4'(s[i]);
    end
    @(negedge clk_i);
    chk_notch(10);
    foreach (s[i])
    begin
      @(negedge clk_i);
      chk_notch(s[i]);
    end
  endtask
  task automatic t_reset();
    @(posedge clk_i);
    rstn_i <= 1'b0;
    @(negedge clk_i);
    chk_vec("isolator", 10'h07f, {3'h0, iso_n});
    chk_pos(TPD_UNDEF, pos);
    do_reset();
    chk_notch(5);
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    do_reset();
    t_sweep();
    t_b2b();
    t_reset();
    final_report();
  end
  initial
  begin
    repeat (500) @(posedge clk_i);
    num_errors++;
    final_report();
  end
endmodule // throttle_position_decoder_tb
bind tpd_throttle_position_decoder tpd_checker tpd_checker_inst (.clk_i(clk_i), .rstn_i(rstn_i), .sol_i(sol_i),
  .isolator_pos_n_o(isolator_pos_n_o), .shorted_res_o(shorted_res_o),
  .rate_control_unit_level_o(rate_control_unit_level_o), .position_o(position_o));

// ### tpd_assertions.sv
module tpd_checker
  import tpd_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire tpd_sol_t   sol_i,
  input wire logic [6:0] isolator_pos_n_o,
  input wire logic [6:0] shorted_res_o,
  input wire logic [9:0] rate_control_unit_level_o,
  input wire tpd_pos_t   position_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] cnt_r;
  tpd_sol_t   d1_r;
  tpd_sol_t   d2_r;
  tpd_sol_t   d3_r;
  wire        ok  = cnt_r == 3'h7;
  // Low idle (first and fourth only) shorts nothing, like code 000
  wire        lo  = d3_r == 4'h9;
  wire  [2:0] n   = lo ? 3'h0 : {d3_r.speed_sol_second, d3_r.speed_sol_third & ~d3_r.speed_sol_fourth,
                                 d3_r.speed_sol_first};
  wire  [6:0] iso = isolator_pos_n_o;
  wire  [6:0] shr = shorted_res_o;
  wire  [9:0] lvl = rate_control_unit_level_o;
  // Reset release and sync stages hide older input history
  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i)
      cnt_r <= 3'h0;
    else if (!ok)
      cnt_r <= cnt_r + 3'h1;
  always_ff @(posedge clk_i)
  begin
    d1_r <= sol_i;
    d2_r <= d1_r;
    d3_r <= d2_r;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////
  property p_hot; ok |-> $countones(~iso) <= 1; endproperty
  a_hot: assert property (p_hot) else $error("isolator not one-hot");
  property p_iso; ok |-> iso == (n == 3'h0 ? 7'h7f : ~(7'h01 << (n - 3'h1))); endproperty
  a_iso: assert property (p_iso) else $error("isolator wrong");
  property p_shr; ok |-> shr == (n == 3'h0 ? 7'h00 : 7'h7f >> (3'h7 - n)); endproperty
  a_shr: assert property (p_shr) else $error("shorted wrong");
  property p_top; ok && n == 3'h7 |-> lvl == TPD_LVL_POS8 && shr == 7'h7f; endproperty
  a_top: assert property (p_top) else $error("top level wrong");
  property p_one; ok && d3_r == 4'h0 |-> lvl == TPD_LVL_POS1 && iso == TPD_ISO_NONE; endproperty
  a_one: assert property (p_one) else $error("idle level wrong");
  property p_stop; ok && n == 3'h0 && d3_r.speed_sol_fourth |-> lvl == TPD_LVL_IDLE; endproperty
  a_stop: assert property (p_stop) else $error("stop level wrong");
  property p_mono; ok && $countones(shr) > $countones($past(shr)) |-> lvl > $past(lvl); endproperty
  a_mono: assert property (p_mono) else $error("level not rising");
  property p_lat; ok && $changed(iso) |-> $past(sol_i, 3) != $past(sol_i, 4); endproperty
  a_lat: assert property (p_lat) else $error("output moved early");
endmodule // tpd_checker

// ### tpd_ctrl_model.sv
module tpd_ctrl_model
  import tpd_pkg::*;
(
  input  wire logic [3:0] notch_i,
  output tpd_sol_t        sol_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Notch 0 stop, 1 low idle, 2 idle, 3..10 positions 1..8
  localparam logic [3:0] SOL [11] = '{4'h1, 4'h9, 4'h0, 4'h0, 4'h8, 4'h2, 4'ha, 4'h7, 4'hf, 4'h6, 4'he};
  assign sol_o = SOL[notch_i];
endmodule // tpd_ctrl_model

// ### tpd_pkg.sv
package tpd_pkg;

  // Decoder input code {first, second, third_not_fourth}
  localparam logic [2:0] TPD_CODE_POS2 = 3'h4;
  localparam logic [2:0] TPD_CODE_POS3 = 3'h1;
  localparam logic [2:0] TPD_CODE_POS4 = 3'h5;
  localparam logic [2:0] TPD_CODE_POS5 = 3'h2;
  localparam logic [2:0] TPD_CODE_POS6 = 3'h6;
  localparam logic [2:0] TPD_CODE_POS7 = 3'h3;
  localparam logic [2:0] TPD_CODE_POS8 = 3'h7;

  // Active-low isolator drive, bit 0 is position 2; all high means none
  localparam logic [6:0] TPD_ISO_NONE  = 7'h7f;
  // Shorted resistor mask, bit 0 is the first series resistor
  localparam logic [6:0] TPD_SHORT_NONE = 7'h00;
  // Output level in tenths of a volt
  localparam logic [9:0] TPD_LVL_IDLE = 10'h000;
  localparam logic [9:0] TPD_LVL_POS1 = 10'd125;
  localparam logic [9:0] TPD_LVL_POS2 = 10'd225;
  localparam logic [9:0] TPD_LVL_POS3 = 10'd312;
  localparam logic [9:0] TPD_LVL_POS4 = 10'd430;
  localparam logic [9:0] TPD_LVL_POS5 = 10'd512;
  localparam logic [9:0] TPD_LVL_POS6 = 10'd573;
  localparam logic [9:0] TPD_LVL_POS7 = 10'd632;
  localparam logic [9:0] TPD_LVL_POS8 = 10'd680;

  // Throttle position as seen from the solenoid pattern
  typedef enum logic [3:0] {
    TPD_STOP, TPD_LOW_IDLE, TPD_IDLE_OR_1, TPD_P2, TPD_P3, TPD_P4,
    TPD_P5, TPD_P6, TPD_P7, TPD_P8, TPD_UNDEF
  } tpd_pos_t;

  typedef struct packed {
    logic speed_sol_first;
    logic speed_sol_second;
    logic speed_sol_third;
    logic speed_sol_fourth;
  } tpd_sol_t;

  typedef struct packed {
    logic [6:0] isolator_n;
    logic [6:0] shorted;
    logic [9:0] level;
  } tpd_out_t;

endpackage

// ### tpd_sync.sv
module tpd_sync
  import tpd_pkg::*;
#(
  parameter int WIDTH = 4
)(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Data
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] q_r;
  logic [WIDTH-1:0] q_nxt;

  always_comb
  begin
    meta_nxt = d_i;
    q_nxt    = meta_r;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= '0;
      q_r    <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      q_r    <= q_nxt;
    end
  end

  assign q_o = q_r;
endmodule // tpd_sync

// ### tpd_throttle_position_decoder.sv
// Notes on behaviour
// [RULE1] Four inputs, one per speed solenoid
// [RULE2] Input one and two follow solenoids directly
// [RULE3] Third input: third solenoid, not fourth
// [RULE4] Three-bit code maps to positions two-eight
// [RULE5] Only one position output active
// [RULE6] Position outputs are active low
// [RULE7] Controller energizes solenoids per position pattern
// [RULE8] Position one: no output, minimum level
// [RULE9] Position two shorts first series resistor
// [RULE10] Higher position removes more resistance
// [RULE11] Position eight bypasses all resistance
// [RULE12] Output levels follow first variant table
// [RULE13] Inputs pass two-stage synchroniser first
module tpd_throttle_position_decoder
  import tpd_pkg::*;
(
  // Clock and reset
  input  wire logic            clk_i,
  input  wire logic            rstn_i,
  // Solenoid energize lines
  input  wire tpd_pkg::tpd_sol_t sol_i,
  // Isolator drives, bit 0 is position 2, active low
  output logic [6:0]           isolator_pos_n_o,
  // Shorted series resistor mask toward the string
  output logic [6:0]           shorted_res_o,
  // Nominal level toward the rate control unit, tenths of a volt
  output logic [9:0]           rate_control_unit_level_o,
  // Decoded position
  output tpd_pkg::tpd_pos_t    position_o
);
  import tpd_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Reset release through two flops: assertion acts at once, release is
  // held back two edges so no flop past these two sees the pin rise close to the clock;
  // a glitch shorter than a clock on the pin still resets the whole block
  logic [1:0] rst_sync_r;
  logic [1:0] rst_sync_nxt;
  logic       rst_n;

  always_comb
  begin
    rst_sync_nxt = {rst_sync_r[0], 1'b1};
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= rst_sync_nxt;
  end
  assign rst_n = rst_sync_r[1];

  ////////////////////////////////////////////////////////////////
  // Input synchroniser; the solenoid lines are slow levels, so two
  // stages of delay cost nothing against the throttle's own response
  tpd_sol_t sol_s;

  // Held in reset by the released copy so it leaves reset with the decode
  tpd_sync #(.WIDTH(4)) u_sync (                // [RULE13]
    .clk_i  (clk_i),
    .rst_n_i(rst_n),
    .d_i    (sol_i),                            // [RULE1]
    .q_o    (sol_s)
  );

  ////////////////////////////////////////////////////////////////
  // Solenoid pattern to throttle position
  logic       third_not_fourth;
  logic [2:0] code;
  tpd_pos_t   pos_nxt;
  tpd_pos_t   pos_r;

  // Stands in for the gate ahead of the decoder; code is first, second,
  // gated third, most significant first
  assign third_not_fourth = sol_s.speed_sol_third & ~sol_s.speed_sol_fourth;                  // [RULE3]
  assign code             = {sol_s.speed_sol_first, sol_s.speed_sol_second, third_not_fourth}; // [RULE2]

  // Low idle energizes the first and fourth solenoids and so presents
  // code 100, like position 2; only the fourth line tells them apart,
  // and low idle must leave the whole string in circuit
  always_comb
  begin
    pos_nxt = TPD_IDLE_OR_1;                                      // [RULE8]
    case (code)                                                   // [RULE4]
      TPD_CODE_POS2:
      begin
        if (sol_s.speed_sol_fourth)
          pos_nxt = TPD_LOW_IDLE;                                 // [RULE12]
        else
          pos_nxt = TPD_P2;
      end
      TPD_CODE_POS3:
      begin
        pos_nxt = TPD_P3;
      end
      TPD_CODE_POS4:
      begin
        pos_nxt = TPD_P4;
      end
      // Positions 5 and 6 keep the fourth solenoid up; the gate hides it
      TPD_CODE_POS5:
      begin
        pos_nxt = TPD_P5;
      end
      TPD_CODE_POS6:
      begin
        pos_nxt = TPD_P6;
      end
      TPD_CODE_POS7:
      begin
        pos_nxt = TPD_P7;
      end
      TPD_CODE_POS8:
      begin
        pos_nxt = TPD_P8;
      end
      default:
      begin
        // Code 000: idle and position 1 energize nothing and look alike,
        // so both report position 1; the fourth solenoid alone is stop
        if (sol_s.speed_sol_fourth)
          pos_nxt = TPD_STOP;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Position to isolator drive, shorted resistors and level; the level
  // is in tenths of a volt of the regulated reference
  tpd_out_t out_nxt;
  tpd_out_t out_r;

  // One isolator low at a time; each position shorts a longer prefix of
  // the string than the one below it, so the level only rises with position
  always_comb
  begin
    out_nxt.isolator_n = TPD_ISO_NONE;
    out_nxt.shorted    = TPD_SHORT_NONE;
    out_nxt.level      = TPD_LVL_IDLE;
    case (pos_nxt)                                                // [RULE5] [RULE6]
      TPD_IDLE_OR_1:
      begin
        out_nxt.level = TPD_LVL_POS1;                             // [RULE8]
      end
      TPD_P2:
      begin
        // Bypasses the first series resistor only
        out_nxt.isolator_n = 7'h7e;
        out_nxt.shorted    = 7'h01;                               // [RULE9]
        out_nxt.level      = TPD_LVL_POS2;                        // [RULE12]
      end
      TPD_P3:
      begin
        // First two resistors bypassed
        out_nxt.isolator_n = 7'h7d;
        out_nxt.shorted    = 7'h03;                               // [RULE10]
        out_nxt.level      = TPD_LVL_POS3;
      end
      TPD_P4:
      begin
        out_nxt.isolator_n = 7'h7b;
        out_nxt.shorted    = 7'h07;
        out_nxt.level      = TPD_LVL_POS4;
      end
      TPD_P5:
      begin
        out_nxt.isolator_n = 7'h77;
        out_nxt.shorted    = 7'h0f;
        out_nxt.level      = TPD_LVL_POS5;
      end
      TPD_P6:
      begin
        out_nxt.isolator_n = 7'h6f;
        out_nxt.shorted    = 7'h1f;
        out_nxt.level      = TPD_LVL_POS6;
      end
      TPD_P7:
      begin
        out_nxt.isolator_n = 7'h5f;
        out_nxt.shorted    = 7'h3f;
        out_nxt.level      = TPD_LVL_POS7;
      end
      TPD_P8:
      begin
        // Whole string bypassed: the full reference reaches the rate control unit
        out_nxt.isolator_n = 7'h3f;
        out_nxt.shorted    = 7'h7f;                               // [RULE11]
        out_nxt.level      = TPD_LVL_POS8;
      end
      default:
      begin
        // Stop and low idle: nothing shorted and no reference level
        out_nxt.level = TPD_LVL_IDLE;                             // [RULE12]
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Output registers; reset shows every isolator off and an undefined
  // position until the first edge after release, which decodes the cleared synchroniser as position 1
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_r <= {TPD_ISO_NONE, TPD_SHORT_NONE, TPD_LVL_IDLE};
      pos_r <= TPD_UNDEF;
    end
    else
    begin
      out_r <= out_nxt;
      pos_r <= pos_nxt;
    end
  end

  // Every output comes straight from a register
  assign isolator_pos_n_o          = out_r.isolator_n;
  assign shorted_res_o             = out_r.shorted;
  assign rate_control_unit_level_o = out_r.level;
  assign position_o                = pos_r;
endmodule // tpd_throttle_position_decoder
